// ===== common/ntb_pkg.sv
// constants shared by the target bus front end and its leaf modules
// assumes a single 100 MHz clock and host pins synchronous to it
package ntb_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int RB_VALID_NS = 10000;    // ready/busy valid after stable
  localparam int RB_UNDEF_NS = 50000;    // undefined after ramp start
  localparam int RB_READY_NS = 1000000;  // ready at the latest
  localparam int READ_NS = 25000;
  localparam int PROG_NS = 200000;
  localparam int ERASE_NS = 2000000;
  localparam int RESET_NS = 5000;
  // least times round up, longest times round down
  localparam int RB_VALID_CYC =
    (RB_VALID_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RB_UNDEF_CYC =
    (RB_UNDEF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RB_READY_CYC = RB_READY_NS / CLOCK_PERIOD_NS;
  localparam int READ_CYC = (READ_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PROG_CYC = (PROG_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ERASE_CYC =
    (ERASE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RESET_CYC =
    (RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ==========================================================
  // command opcodes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONF = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_CONF = 8'h10;
  localparam logic [7:0] CMD_CACHE_CONF = 8'h11;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONF = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_SEL = 8'h78;
  localparam logic [7:0] CMD_RESET = 8'hff;

  // ==========================================================
  // status byte layout
  localparam int ST_FAIL = 0;
  localparam int ST_ARRAY_RDY = 5;
  localparam int ST_READY = 6;   // lun_ready_status_bit
  localparam int ST_WP_N = 7;

  localparam int SYNC_STAGES = 3;
  localparam int CNT_W = 24;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10,
    OP_RESET = 2'b11
  } ntb_op_t;

  typedef enum logic {
    LS_IDLE = 1'b0,
    LS_BUSY = 1'b1
  } ntb_lun_state_t;

endpackage

// ===== src/ntb_sync.sv
// multi-stage synchroniser for one asynchronous level
// assumes the source may change at any time
`timescale 1ns/1ps
module ntb_sync import ntb_pkg::*; #(
  parameter int STAGES = SYNC_STAGES,
  parameter logic INIT = 1'b0
) (
  input wire logic clk,    // system clock
  input wire logic srst,   // synchronous reset
  input wire logic async_in, // raw level
  output logic sync_out    // level in clock domain
);
  logic [STAGES-1:0] chain;

  // first stage feeds only the next stage
  always_ff @(posedge clk) begin
    if (srst) begin
      chain <= {STAGES{INIT}};
    end else begin
      chain <= {chain[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain[STAGES-1];
endmodule

// ===== src/ntb_lun.sv
// one logical unit: busy timer, status byte and page register flag
// assumes start pulses only while ready; front end guards read, program and erase, not reset
`timescale 1ns/1ps
module ntb_lun import ntb_pkg::*; #(
  parameter int READ_CYCLES = READ_CYC,
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input wire logic clk,        // system clock
  input wire logic srst,       // synchronous reset
  input wire logic por_done,   // power-up init finished
  input wire logic start,      // one-cycle operation start
  input wire ntb_op_t op,      // operation kind
  input wire logic wp_ok,      // program/erase allowed
  input wire logic clear_page, // drop page data if idle
  output logic ready,          // idle and initialised
  output logic [7:0] status,   // status byte
  output logic page_valid      // page register holds data
);
  ntb_lun_state_t state;
  logic [CNT_W-1:0] cnt;
  logic fail;
  ntb_op_t cur_op;
  logic blocked;

  assign blocked = (op == OP_PROG || op == OP_ERASE) && !wp_ok;

  // ==========================================================
  // operation timer, independent of every other lun
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= LS_IDLE;
      cnt <= '0;
      fail <= 1'b0;
      cur_op <= OP_RESET;
    end else begin
      unique case (state)
        LS_IDLE: begin
          if (start && blocked) begin
            fail <= 1'b1;
          end else if (start) begin
            state <= LS_BUSY;
            cur_op <= op;
            fail <= 1'b0;
            unique case (op)
              OP_READ: cnt <= CNT_W'(READ_CYCLES - 1);
              OP_PROG: cnt <= CNT_W'(PROG_CYCLES - 1);
              OP_ERASE: cnt <= CNT_W'(ERASE_CYCLES - 1);
              OP_RESET: cnt <= CNT_W'(RESET_CYC - 1);
            endcase
          end
        end
        LS_BUSY: begin
          if (cnt == '0) begin
            state <= LS_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // page register contents; completion wins over a clear
  always_ff @(posedge clk) begin
    if (srst) begin
      page_valid <= 1'b0;
    end else if (state == LS_BUSY && cnt == '0 && cur_op == OP_READ) begin
      page_valid <= 1'b1;
    end else if (start && !blocked && op != OP_PROG) begin
      page_valid <= 1'b0;
    end else if (clear_page && state == LS_IDLE) begin
      page_valid <= 1'b0;
    end
  end

  assign ready = (state == LS_IDLE) && por_done;

  always_comb begin
    status = 8'h00;
    status[ST_FAIL] = fail;
    status[ST_ARRAY_RDY] = ready;
    status[ST_READY] = ready;
    status[ST_WP_N] = wp_ok;
  end
endmodule

// ===== src/ntb_target_bus.sv
// four-target front end: bus mapping, command and address decode,
// lun status, ready/busy and write-protect gating
// assumes host pins are synchronous to CLOCK and strobes are slow
// enough to be seen as levels for at least one cycle each
`timescale 1ns/1ps
module ntb_target_bus import ntb_pkg::*; #(
  parameter bit DUAL_BUS = 1'b1,         // two independent x8 buses
  parameter bit WIDE_BUS = 1'b0,         // 16-bit data, only with DUAL_BUS and SOURCE_SYNC off
  parameter bit SOURCE_SYNC = 1'b0,      // source-synchronous capable
  parameter int LUNS = 2,                // luns per target
  parameter int PAGE_BYTES = 2048,
  parameter int PAGES_PER_BLOCK = 128,
  parameter int BLOCKS = 1024,
  parameter int COL_CYCLES = 2,
  parameter int ROW_CYCLES = 3,
  parameter int RB_UNDEF_CYCLES = RB_UNDEF_CYC,
  parameter int RB_READY_CYCLES = RB_READY_CYC,
  parameter int READ_CYCLES = READ_CYC,
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  input wire logic CLOCK,                  // 100 MHz clock
  input wire logic SRST,                   // synchronous reset
  input wire logic FIRST_TARGET_SELECT_N,  // target 1 select
  input wire logic SECOND_TARGET_SELECT_N, // target 2 select
  input wire logic THIRD_TARGET_SELECT_N,  // target 3 select
  input wire logic FOURTH_TARGET_SELECT_N, // target 4 select
  input wire logic [1:0] CMD_LATCH,        // command latch per bus
  input wire logic [1:0] ADDR_LATCH,       // address latch per bus
  input wire logic [1:0] WRITE_STROBE_N,   // write strobe per bus
  input wire logic [1:0] READ_ENABLE_N,    // read enable per bus
  input wire logic [1:0] WRITE_PROTECT_N,  // write protect per bus
  input wire logic [15:0] DATA_IN0,        // bus one data in
  input wire logic [7:0] DATA_IN1,         // bus two data in
  output logic [15:0] DATA_OUT0,           // bus one data out
  output logic DATA_OE0,                   // bus one drive enable
  output logic [7:0] DATA_OUT1,            // bus two data out
  output logic DATA_OE1,                   // bus two drive enable
  output logic [3:0] READY_BUSY_OUT,       // open-drain level, always 0
  output logic [3:0] READY_BUSY_OE,        // pulls ready/busy low
  output logic [3:0] LOW_POWER,            // target in low-power state
  output logic ADDR_FAULT                  // bad address cycle pulse
);
  localparam int NT = 4;
  // dual buses are x8 each, so a wide bus one would split the widths
  localparam bit BUS16 = WIDE_BUS && !SOURCE_SYNC && !DUAL_BUS;
  localparam int PAGE_BITS = $clog2(PAGES_PER_BLOCK);
  localparam int BLOCK_BITS = $clog2(BLOCKS);
  localparam int LUN_BITS = $clog2(LUNS);
  localparam int AW = (COL_CYCLES + ROW_CYCLES) * 8;
  localparam int LUN_POS = PAGE_BITS + BLOCK_BITS;

  logic [NT-1:0] sel;
  logic [1:0] we_prev;
  logic [1:0] wp_ok;
  logic [CNT_W-1:0] por_cnt;
  logic rb_valid;
  logic por_done;
  logic [NT-1:0][LUNS-1:0] lun_ready;
  logic [NT-1:0][LUNS-1:0] lun_start;
  logic [NT-1:0][LUNS-1:0][7:0] lun_status;
  logic [NT-1:0][LUNS-1:0] lun_page;
  ntb_op_t [NT-1:0] lun_op;
  logic [NT-1:0] clr_page;
  logic [NT-1:0] status_mode;
  logic [NT-1:0][LUN_BITS-1:0] out_lun;
  logic [NT-1:0] fault;
  logic [NT-1:0] drive;
  logic [NT-1:0][7:0] drive_byte;
  logic [NT-1:0] low_power;
  logic next_oe0;
  logic next_oe1;
  logic [7:0] next_out0;
  logic [7:0] next_out1;

  assign sel = ~{FOURTH_TARGET_SELECT_N, THIRD_TARGET_SELECT_N,
                 SECOND_TARGET_SELECT_N, FIRST_TARGET_SELECT_N};

  // ==========================================================
  // write protect and strobe sampling
  for (genvar b = 0; b < 2; b++) begin : g_bus
    ntb_sync #(.STAGES(SYNC_STAGES), .INIT(1'b0)) u_wp_sync (
      .clk(CLOCK),
      .srst(SRST),
      .async_in(WRITE_PROTECT_N[b]),
      .sync_out(wp_ok[b])
    );
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      we_prev <= 2'b11;
    end else begin
      we_prev <= WRITE_STROBE_N;
    end
  end

  // ==========================================================
  // power-up timing of ready/busy
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      por_cnt <= '0;
    end else if (por_cnt != CNT_W'(RB_READY_CYCLES)) begin
      por_cnt <= por_cnt + 1'b1;
    end
  end

  // undefined span covers the earlier valid point as well
  assign rb_valid = (por_cnt >= CNT_W'(RB_UNDEF_CYCLES)) &&
                    (por_cnt >= CNT_W'(RB_VALID_CYC));
  assign por_done = (por_cnt == CNT_W'(RB_READY_CYCLES));

  // ==========================================================
  // per-target decode
  for (genvar t = 0; t < NT; t++) begin : g_tgt
    localparam int B = (DUAL_BUS && (t % 2 == 1)) ? 1 : 0;
    logic latch;
    logic cmd_cyc;
    logic addr_cyc;
    logic [7:0] dbyte;
    logic [7:0] upper;
    logic [7:0] cmd;
    logic [3:0] acnt;
    logic [AW-1:0] addr;
    logic [AW-1:0] next_addr;
    logic row_only;
    logic [3:0] idx;
    logic cache_prev;
    logic [LUN_BITS-1:0] tgt_lun;
    logic [LUN_BITS-1:0] next_lun;

    assign latch = sel[t] && !we_prev[B] && WRITE_STROBE_N[B];
    assign cmd_cyc = CMD_LATCH[B] && !ADDR_LATCH[B];
    assign addr_cyc = ADDR_LATCH[B] && !CMD_LATCH[B];
    assign dbyte = (B == 1) ? DATA_IN1 : DATA_IN0[7:0];
    assign upper = (B == 0 && BUS16) ? DATA_IN0[15:8] : 8'h00;
    assign row_only = (cmd == CMD_ERASE_SETUP) ||
                      (cmd == CMD_STATUS_SEL);
    assign idx = row_only ? 4'(COL_CYCLES) + acnt : acnt;

    always_comb begin
      next_addr = addr;
      next_addr[idx*8 +: 8] = dbyte;
    end

    assign tgt_lun = addr[COL_CYCLES*8 + LUN_POS +: LUN_BITS];
    assign next_lun = next_addr[COL_CYCLES*8 + LUN_POS +: LUN_BITS];

    always_ff @(posedge CLOCK) begin
      if (SRST) begin
        low_power[t] <= 1'b1;
        cmd <= 8'h00;
        acnt <= 4'h0;
        addr <= '0;
        cache_prev <= 1'b0;
        status_mode[t] <= 1'b0;
        out_lun[t] <= '0;
        lun_start[t] <= '0;
        lun_op[t] <= OP_RESET;
        clr_page[t] <= 1'b0;
        fault[t] <= 1'b0;
      end else begin
        lun_start[t] <= '0;
        clr_page[t] <= 1'b0;
        fault[t] <= 1'b0;
        if (latch && cmd_cyc && (!low_power[t] || dbyte == CMD_RESET)) begin
          cmd <= dbyte;
          acnt <= 4'h0;
          status_mode[t] <= 1'b0;
          case (dbyte)
            CMD_RESET: begin
              low_power[t] <= 1'b0;
              lun_start[t] <= '1;
              lun_op[t] <= OP_RESET;
              out_lun[t] <= '0;
              cache_prev <= 1'b0;
            end
            CMD_STATUS: status_mode[t] <= 1'b1;
            CMD_PROG_SETUP: clr_page[t] <= !cache_prev;
            CMD_READ_CONF: begin
              lun_start[t][tgt_lun] <= lun_ready[t][tgt_lun];
              lun_op[t] <= OP_READ;
            end
            CMD_PROG_CONF, CMD_CACHE_CONF: begin
              lun_start[t][tgt_lun] <= lun_ready[t][tgt_lun];
              lun_op[t] <= OP_PROG; // gated inside the lun
              cache_prev <= (dbyte == CMD_CACHE_CONF);
            end
            CMD_ERASE_CONF: begin
              lun_start[t][tgt_lun] <= lun_ready[t][tgt_lun];
              lun_op[t] <= OP_ERASE;
            end
            default: ;
          endcase
        end else if (latch && addr_cyc && !low_power[t]) begin
          if (idx < 4'(COL_CYCLES + ROW_CYCLES)) begin
            addr <= next_addr;
            acnt <= acnt + 1'b1;
          end
          // wide bus address cycles must carry zero upper byte
          if (upper != 8'h00) begin
            fault[t] <= 1'b1;
          end
          if (SOURCE_SYNC && !row_only && acnt == 4'h0 && dbyte[0]) begin
            fault[t] <= 1'b1;
          end
          if (cmd == CMD_STATUS_SEL && acnt == 4'(ROW_CYCLES - 1)) begin
            out_lun[t] <= next_lun;
            status_mode[t] <= 1'b1;
          end
        end
      end
    end

    // only the selected lun drives; the others stay off
    assign drive[t] = sel[t] && status_mode[t] && !READ_ENABLE_N[B];
    assign drive_byte[t] = lun_status[t][out_lun[t]];

    for (genvar l = 0; l < LUNS; l++) begin : g_lun
      ntb_lun #(
        .READ_CYCLES(READ_CYCLES),
        .PROG_CYCLES(PROG_CYCLES),
        .ERASE_CYCLES(ERASE_CYCLES)
      ) u_lun (
        .clk(CLOCK),
        .srst(SRST),
        .por_done(por_done),
        .start(lun_start[t][l]),
        .op(lun_op[t]),
        .wp_ok(wp_ok[B]),
        .clear_page(clr_page[t]),
        .ready(lun_ready[t][l]),
        .status(lun_status[t][l]),
        .page_valid(lun_page[t][l])
      );
    end
  end

  // ==========================================================
  // data bus return path
  always_comb begin
    next_oe0 = 1'b0;
    next_oe1 = 1'b0;
    next_out0 = 8'h00;
    next_out1 = 8'h00;
    for (int t = 0; t < NT; t++) begin
      if (drive[t] && DUAL_BUS && (t % 2 == 1)) begin
        next_oe1 = 1'b1;
        next_out1 = next_out1 | drive_byte[t];
      end else if (drive[t]) begin
        next_oe0 = 1'b1;
        next_out0 = next_out0 | drive_byte[t];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      DATA_OUT0 <= 16'h0000;
      DATA_OE0 <= 1'b0;
      DATA_OUT1 <= 8'h00;
      DATA_OE1 <= 1'b0;
    end else begin
      DATA_OUT0 <= {8'h00, next_out0}; // status sits in the low byte
      DATA_OE0 <= next_oe0;
      DATA_OUT1 <= next_out1;
      DATA_OE1 <= next_oe1;
    end
  end

  // ==========================================================
  // ready/busy, open drain: pull low while any lun busy
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      READY_BUSY_OE <= 4'h0;
      ADDR_FAULT <= 1'b0;
      LOW_POWER <= 4'hf;
    end else begin
      for (int t = 0; t < NT; t++) begin
        READY_BUSY_OE[t] <= rb_valid && !(&lun_ready[t]);
      end
      ADDR_FAULT <= |fault;
      LOW_POWER <= low_power;
    end
  end

  assign READY_BUSY_OUT = 4'h0;
endmodule

// ===== test/ntb_sva.sv
// checker for the flash target bus front end
// sees only top module ports; bound from the bench top file
`timescale 1ns/1ps
module ntb_sva import ntb_pkg::*; #(
  parameter int RB_UNDEF_CYCLES = RB_UNDEF_CYC,
  parameter int RB_READY_CYCLES = RB_READY_CYC
) (
  input wire logic CLOCK, // clock
  input wire logic SRST, // reset
  input wire logic [1:0] CMD_LATCH, // command latch
  input wire logic [1:0] READ_ENABLE_N, // read enable
  input wire logic [15:0] DATA_IN0, // bus one data
  input wire logic [7:0] DATA_IN1, // bus two data
  input wire logic DATA_OE0, // bus one drive
  input wire logic DATA_OE1, // bus two drive
  input wire logic [3:0] READY_BUSY_OUT, // ready/busy level
  input wire logic [3:0] READY_BUSY_OE, // ready/busy pull
  input wire logic [3:0] LOW_POWER, // low-power flags
  input wire logic ADDR_FAULT // bad address pulse
);
  // ==========================================================
  // cycles since reset release
  localparam int BUSY_LO = 2 +
    ((RB_UNDEF_CYCLES > RB_VALID_CYC) ? RB_UNDEF_CYCLES : RB_VALID_CYC);
  int cnt;
  default clocking cb @(posedge CLOCK); endclocking
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cnt <= 0;
    end else if (cnt < RB_READY_CYCLES + 8) begin
      cnt <= cnt + 1;
    end
  end
  // ==========================================================
  // properties
  // no disable here: the reset itself is the cause
  property p_rst;
    SRST |=> (!DATA_OE0 && !DATA_OE1 && READY_BUSY_OE == 4'h0 &&
      LOW_POWER == 4'hf && !ADDR_FAULT);
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_undef;
    disable iff (SRST) (cnt < RB_UNDEF_CYCLES - 1) |-> READY_BUSY_OE == 4'h0;
  endproperty
  a_undef: assert property (p_undef) else $error("early pull");
  property p_busy;
    disable iff (SRST) (cnt > BUSY_LO && cnt < RB_READY_CYCLES - 2)
      |-> READY_BUSY_OE == 4'hf;
  endproperty
  a_busy: assert property (p_busy) else $error("not busy in powerup");
  property p_ready;
    disable iff (SRST) (cnt == RB_READY_CYCLES - 3)
      |-> ##[1:8] (READY_BUSY_OE == 4'h0);
  endproperty
  a_ready: assert property (p_ready) else $error("ready too late");
  property p_rb_out;
    disable iff (SRST) READY_BUSY_OUT == 4'h0;
  endproperty
  a_rb_out: assert property (p_rb_out) else $error("rb level");
  property p_lp_up;
    disable iff (SRST) (LOW_POWER & ~$past(LOW_POWER)) == 4'h0;
  endproperty
  a_lp_up: assert property (p_lp_up) else $error("low power re-entered");
  property p_lp0;
    disable iff (SRST) $fell(LOW_POWER[0])
      |-> $past(DATA_IN0[7:0]) == 8'hff && $past(CMD_LATCH[0]);
  endproperty
  a_lp0: assert property (p_lp0) else $error("wake without reset");
  property p_lp1;
    disable iff (SRST) $fell(LOW_POWER[1])
      |-> $past(DATA_IN1) == 8'hff && $past(CMD_LATCH[1]);
  endproperty
  a_lp1: assert property (p_lp1) else $error("wake on wrong bus");
  property p_oe0;
    disable iff (SRST) DATA_OE0 |-> !$past(READ_ENABLE_N[0]);
  endproperty
  a_oe0: assert property (p_oe0) else $error("bus one drive");
  property p_oe1;
    disable iff (SRST) DATA_OE1 |-> !$past(READ_ENABLE_N[1]);
  endproperty
  a_oe1: assert property (p_oe1) else $error("bus two drive");
  property p_fault;
    disable iff (SRST) ADDR_FAULT |=> !ADDR_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("fault too long");
endmodule

// ===== test/ntb_host.sv
// host controller model driving the flash target pins
// assumes the bench calls one task at a time
`timescale 1ns/1ps
module ntb_host (
  input wire logic clk, // system clock
  input wire logic [7:0] q0, // bus one data out
  input wire logic oe0, // bus one drive
  input wire logic [7:0] q1, // bus two data out
  input wire logic oe1, // bus two drive
  output logic [3:0] sel_n, // target selects
  output logic [1:0] cl, // command latch
  output logic [1:0] al, // address latch
  output logic [1:0] ws_n, // write strobe
  output logic [1:0] re_n, // read enable
  output logic [1:0] wp_n, // write protect
  output logic [15:0] d0, // bus one data
  output logic [7:0] d1 // bus two data
);
  initial begin
    sel_n = 4'hf;
    cl = 2'h0;
    al = 2'h0;
    ws_n = 2'h3;
    re_n = 2'h3;
    wp_n = 2'h3;
    d0 = 16'h0;
    d1 = 8'h0;
  end
  // strobe phases of two clocks; select stays low until idle
  task automatic put(int b, t, bit c, a, logic [7:0] v, up);
    @(posedge clk);
    sel_n[t] <= 1'b0;
    cl[b] <= c;
    al[b] <= a;
    ws_n[b] <= 1'b0;
    if (b == 0) d0 <= {up, v};
    else d1 <= v;
    repeat (2) @(posedge clk);
    ws_n[b] <= 1'b1;
    repeat (2) @(posedge clk);
    cl[b] <= 1'b0;
    al[b] <= 1'b0;
    // released lines show the inverse, never a stale match
    d0 <= ~d0;
    d1 <= ~d1;
  endtask
  task automatic cmd(int b, t, logic [7:0] v, up);
    put(b, t, 1'b1, 1'b0, v, up);
  endtask
  task automatic col(int b, t, logic [15:0] c);
    for (int i = 0; i < 2; i++) begin
      put(b, t, 1'b0, 1'b1, c[8*i+:8], 8'h00);
    end
  endtask
  task automatic row(int b, t, logic [23:0] r);
    for (int i = 0; i < 3; i++) begin
      put(b, t, 1'b0, 1'b1, r[8*i+:8], 8'h00);
    end
  endtask
  task automatic idle();
    @(posedge clk);
    sel_n <= 4'hf;
    @(posedge clk);
  endtask
  task automatic rd(int b, t, output logic [8:0] v);
    @(posedge clk);
    sel_n[t] <= 1'b0;
    re_n[b] <= 1'b0;
    repeat (3) @(posedge clk);
    v = (b == 0) ? {oe0, q0} : {oe1, q1};
    re_n[b] <= 1'b1;
    idle();
  endtask
endmodule

// ===== test/test_ntb_target_bus.sv
// bench for the four-target flash bus front end
// assumes the host model in ntb_host and the checker in ntb_sva
`timescale 1ns/1ps
module test_ntb_target_bus import ntb_pkg::*;;
  localparam int ER = 200;
  localparam int SETTLE = 100; // protect_settle_time, chosen
  logic CLOCK = 1'b0;
  logic SRST = 1'b1;
  logic [3:0] sel_n;
  logic [1:0] cl, al, ws_n, re_n, wp_n;
  logic [15:0] d0, q0;
  logic [7:0] d1, q1;
  logic oe0, oe1, fault;
  logic [3:0] rb_out, rb_oe, lp;
  int seed = 2881;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_fault = 0;
  always #5 CLOCK = ~CLOCK;
  // fault pulses counted on the falling edge, where the flag is settled
  always @(negedge CLOCK) begin
    if (!SRST && fault !== 1'b0) n_fault++;
  end
  ntb_host i_host (.clk(CLOCK), .q0(q0[7:0]), .oe0(oe0), .q1(q1),
    .oe1(oe1), .sel_n(sel_n), .cl(cl), .al(al), .ws_n(ws_n),
    .re_n(re_n), .wp_n(wp_n), .d0(d0), .d1(d1));
  ntb_target_bus #(.RB_UNDEF_CYCLES(20), .RB_READY_CYCLES(1100),
    .READ_CYCLES(10), .PROG_CYCLES(20), .ERASE_CYCLES(ER)) i_dut (
    .CLOCK(CLOCK), .SRST(SRST), .FIRST_TARGET_SELECT_N(sel_n[0]),
    .SECOND_TARGET_SELECT_N(sel_n[1]), .THIRD_TARGET_SELECT_N(sel_n[2]),
    .FOURTH_TARGET_SELECT_N(sel_n[3]), .CMD_LATCH(cl), .ADDR_LATCH(al),
    .WRITE_STROBE_N(ws_n), .READ_ENABLE_N(re_n), .WRITE_PROTECT_N(wp_n),
    .DATA_IN0(d0), .DATA_IN1(d1), .DATA_OUT0(q0), .DATA_OE0(oe0),
    .DATA_OUT1(q1), .DATA_OE1(oe1), .READY_BUSY_OUT(rb_out),
    .READY_BUSY_OE(rb_oe), .LOW_POWER(lp), .ADDR_FAULT(fault));
  // ==========================================================
  // expectations and checks
  function automatic int bus(int t);
    return t % 2;
  endfunction
  function automatic logic [23:0] row_of(bit lun, logic [9:0] b,
    logic [6:0] p);
    return {6'h00, lun, b, p};
  endfunction
  function automatic logic [8:0] stx(bit wp, rdy, fail);
    return {1'b1, wp, rdy, 5'h00, fail};
  endfunction
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rs(int b, t, bit enh, lun, logic [8:0] e, string nm);
    logic [8:0] r;
    if (enh) begin
      i_host.cmd(b, t, CMD_STATUS_SEL, 8'($random(seed)));
      i_host.row(b, t, row_of(lun, 10'h0, 7'h0));
    end else i_host.cmd(b, t, CMD_STATUS, 8'($random(seed)));
    i_host.rd(b, t, r);
    chk(nm, e, {r[8], r[7:0] & 8'hc1});
  endtask
  task automatic erase(bit lun);
    i_host.cmd(0, 0, CMD_ERASE_SETUP, 8'($random(seed)));
    i_host.row(0, 0, row_of(lun, 10'($random(seed)), 7'h0));
    i_host.cmd(0, 0, CMD_ERASE_CONF, 8'($random(seed)));
    i_host.idle();
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial begin
    logic [8:0] r;
    repeat (5) @(posedge CLOCK);
    SRST <= 1'b0;
    repeat (10) @(posedge CLOCK);
    chk("rb_early", 9'h0, {5'h0, rb_oe});
    chk("low_power", 9'h00f, {5'h0, lp});
    repeat (1050) @(posedge CLOCK);
    chk("rb_powerup", 9'h00f, {5'h0, rb_oe});
    repeat (100) @(posedge CLOCK);
    chk("rb_ready", 9'h0, {5'h0, rb_oe});
    i_host.cmd(0, 0, CMD_STATUS, 8'h5a);
    i_host.rd(0, 0, r);
    chk("oe_low_power", 9'h0, {8'h0, r[8]});
    i_host.cmd(0, 1, CMD_RESET, 8'h00);
    i_host.idle();
    chk("wrong_bus", 9'h00f, {5'h0, lp});
    for (int t = 0; t < 4; t++) begin
      i_host.cmd(bus(t), t, CMD_RESET, 8'($random(seed)));
      i_host.idle();
      chk("rb_reset", 9'h1, {8'h0, rb_oe[t]});
    end
    chk("awake", 9'h0, {5'h0, lp});
    repeat (520) @(posedge CLOCK);
    chk("rb_idle", 9'h0, {5'h0, rb_oe});
    for (int t = 0; t < 4; t++) begin
      rs(bus(t), t, 0, 0, stx(1, 1, 0), "status");
    end
    // change protect only while idle, then keep the bus quiet
    i_host.wp_n[0] <= 1'b0;
    repeat (SETTLE) @(posedge CLOCK);
    erase(0);
    chk("rb_protected", 9'h0, {8'h0, rb_oe[0]});
    i_host.cmd(0, 0, CMD_PROG_SETUP, 8'($random(seed)));
    i_host.col(0, 0, 16'h0000);
    i_host.row(0, 0, row_of(0, 10'($random(seed)), 7'h0));
    i_host.cmd(0, 0, CMD_PROG_CONF, 8'($random(seed)));
    i_host.idle();
    chk("rb_prog_protected", 9'h0, {8'h0, rb_oe[0]});
    rs(0, 0, 0, 0, stx(0, 1, 1), "status_protected");
    i_host.wp_n[0] <= 1'b1;
    repeat (SETTLE) @(posedge CLOCK);
    erase(1);
    i_host.cmd(0, 0, CMD_READ_SETUP, 8'($random(seed)));
    i_host.col(0, 0, {5'h00, 11'($random(seed))});
    i_host.row(0, 0, row_of(0, 10'($random(seed)), 7'($random(seed))));
    i_host.cmd(0, 0, CMD_READ_CONF, 8'($random(seed)));
    i_host.idle();
    chk("rb_two_luns", 9'h1, {8'h0, rb_oe[0]});
    repeat (15) @(posedge CLOCK);
    rs(0, 0, 1, 0, stx(1, 1, 0), "lun0_ready");
    chk("rb_and", 9'h1, {8'h0, rb_oe[0]});
    rs(0, 0, 1, 1, stx(1, 0, 0), "lun1_busy");
    // upper pins carry no meaning on an 8-bit bus, even in address cycles
    i_host.cmd(0, 0, CMD_READ_SETUP, 8'($random(seed)));
    i_host.put(0, 0, 1'b0, 1'b1, 8'h00, 8'h5a);
    i_host.idle();
    repeat (ER) @(posedge CLOCK);
    chk("rb_done", 9'h0, {5'h0, rb_oe});
    chk("addr_fault", 9'h0, 9'(n_fault));
    final_report();
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    n_mismatch++;
    final_report();
  end
endmodule
bind ntb_target_bus ntb_sva #(
  .RB_UNDEF_CYCLES(RB_UNDEF_CYCLES),
  .RB_READY_CYCLES(RB_READY_CYCLES)
) i_sva (
  .CLOCK(CLOCK), .SRST(SRST), .CMD_LATCH(CMD_LATCH),
  .READ_ENABLE_N(READ_ENABLE_N), .DATA_IN0(DATA_IN0),
  .DATA_IN1(DATA_IN1), .DATA_OE0(DATA_OE0), .DATA_OE1(DATA_OE1),
  .READY_BUSY_OUT(READY_BUSY_OUT), .READY_BUSY_OE(READY_BUSY_OE),
  .LOW_POWER(LOW_POWER), .ADDR_FAULT(ADDR_FAULT)
);
